// [verilog/smls_pkg.sv]
/*
 * shared constants and types of the health-monitoring subcommand block:
 * task-file register map, subcommand codes, answer codes, attribute data
 * structure layout and the carrier structs.
 * assumes a single 100 MHz clock and a plain strobe register port.
 */
package smls_pkg;

	localparam int CLK_MHZ = 100;
	localparam int ADDR_W = 6;
	localparam int SECTOR_BYTES = 512;
	localparam int LOG_SLOTS = 37;

	// task-file style register map, byte addresses
	localparam logic [5:0] REG_FEATURE = 6'h00;
	localparam logic [5:0] REG_SECCNT = 6'h04;
	localparam logic [5:0] REG_LBA_LOW = 6'h08;
	localparam logic [5:0] REG_LBA_MID = 6'h0C;
	localparam logic [5:0] REG_LBA_HIGH = 6'h10;
	localparam logic [5:0] REG_CMD_STAT = 6'h14;
	localparam logic [5:0] REG_ERROR = 6'h18;
	localparam logic [5:0] REG_DATA = 6'h1C;
	localparam logic [5:0] REG_FEAT_STATE = 6'h20;

	// status and error bit positions
	localparam int STAT_ERR_BIT = 0;
	localparam int STAT_DRQ_BIT = 3;
	localparam int STAT_DRDY_BIT = 6;
	localparam int STAT_BSY_BIT = 7;
	localparam int ERR_ABRT_BIT = 2;

	localparam logic [7:0] CMD_HEALTH = 8'hB0;
	localparam logic [7:0] SUB_READ_ATTR = 8'hD0;
	localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;
	localparam logic [7:0] SUB_SAVE_ATTR = 8'hD3;
	localparam logic [7:0] SUB_EXEC_IMM = 8'hD4;
	localparam logic [7:0] SUB_READ_LOG = 8'hD5;
	localparam logic [7:0] SUB_WRITE_LOG = 8'hD6;
	localparam logic [7:0] SUB_ENABLE = 8'hD8;
	localparam logic [7:0] SUB_DISABLE = 8'hD9;
	localparam logic [7:0] SUB_STATUS = 8'hDA;
	localparam logic [7:0] SUB_AUTO_OFF = 8'hDB;

	localparam logic [7:0] SC_AUTO_OFF_DIS = 8'h00;
	localparam logic [7:0] SC_SCAN_DIS = 8'h01;
	localparam logic [7:0] SC_AUTOSAVE_EN = 8'hF1;
	localparam logic [7:0] SC_AUTO_OFF_EN = 8'hF8;
	localparam logic [7:0] SC_SCAN_EN = 8'hF9;
	localparam logic [7:0] SC_ONE = 8'h01;
	localparam logic [7:0] EXEC_OFFLINE = 8'h00;

	localparam logic [7:0] HEALTH_OK_MID = 8'h4F;
	localparam logic [7:0] HEALTH_OK_HIGH = 8'hC2;
	localparam logic [7:0] HEALTH_BAD_MID = 8'hF4;
	localparam logic [7:0] HEALTH_BAD_HIGH = 8'h2C;

	// log addresses
	localparam logic [7:0] LOG_DIR = 8'h00;
	localparam logic [7:0] LOG_ERR = 8'h01;
	localparam logic [7:0] LOG_COMP_ERR = 8'h02;
	localparam logic [7:0] LOG_SELFTEST = 8'h06;
	localparam logic [7:0] LOG_SELECTIVE = 8'h09;
	localparam logic [7:0] LOG_VENDOR_LO = 8'h80;
	localparam logic [7:0] LOG_VENDOR_HI = 8'h9F;

	// attribute data structure layout
	localparam logic [15:0] ATTR_REVISION = 16'h0010;
	localparam logic [8:0] OFS_ENTRIES = 9'h002;
	localparam logic [8:0] OFS_OFFL_STAT = 9'h16A;
	localparam logic [8:0] OFS_ST_STAT = 9'h16B;
	localparam logic [8:0] OFS_OFFL_TIME = 9'h16C;
	localparam logic [8:0] OFS_SEG_PTR = 9'h16E;
	localparam logic [8:0] OFS_OFFL_CAP = 9'h16F;
	localparam logic [8:0] OFS_MON_CAP = 9'h170;
	localparam logic [8:0] OFS_ERRLOG_CAP = 9'h172;
	localparam logic [8:0] OFS_CHKPT = 9'h173;
	localparam logic [8:0] OFS_SHORT_MIN = 9'h174;
	localparam logic [8:0] OFS_EXT_MIN = 9'h175;
	localparam logic [8:0] OFS_CHECKSUM = 9'h1FF;
	localparam logic [7:0] VAL_OFFL_CAP = 8'h5B;
	localparam logic [15:0] VAL_MON_CAP = 16'h0003;
	localparam logic [7:0] VAL_ERRLOG_CAP = 8'h01;
	localparam logic [8:0] LAST_BYTE = 9'h1FF;

	typedef enum logic [3:0] {
		SMLS_IDLE = 4'b0001,
		SMLS_RD = 4'b0010,
		SMLS_WR = 4'b0100,
		SMLS_BUSY = 4'b1000
	} smls_fsm_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} smls_bus_t;

	// drive-side figures placed into the attribute structure
	typedef struct packed {
		logic [7:0] offl_stat;
		logic [7:0] st_stat;
		logic [15:0] offl_time;
		logic [7:0] seg_ptr;
		logic [7:0] chkpt;
		logic [7:0] short_min;
		logic [7:0] ext_min;
	} smls_devstat_t;

	// persistent feature state
	typedef struct packed {
		logic mon_en;
		logic autosave;
		logic auto_off;
		logic read_scan;
	} smls_feat_t;

	typedef struct packed {
		logic valid;
		logic writable;
		logic [5:0] slot;
	} smls_logmap_t;

	function automatic smls_logmap_t smls_log_map(input logic [7:0] a);
		smls_logmap_t m;
		m = '{valid: 1'b1, writable: 1'b0, slot: 6'h00};
		if (a == LOG_DIR) m.slot = 6'h00;
		else if (a == LOG_ERR) m.slot = 6'h01;
		else if (a == LOG_COMP_ERR) m.slot = 6'h02;
		else if (a == LOG_SELFTEST) m.slot = 6'h03;
		else if (a == LOG_SELECTIVE) begin
			m.slot = 6'h04;
			m.writable = 1'b1;
		end else if (a >= LOG_VENDOR_LO && a <= LOG_VENDOR_HI) begin
			m.slot = 6'(a - LOG_VENDOR_LO + 8'h05);
			m.writable = 1'b1;
		end else m.valid = 1'b0;
		return m;
	endfunction

endpackage

// [verilog/smls_log_ram.sv]
/*
 * log sector storage: one 512-byte sector per mapped log address,
 * one write port, asynchronous read.
 * assumes the caller muxes host and firmware writes onto the one port.
 */
`timescale 1ns/1ps
`default_nettype none
module smls_log_ram
	import smls_pkg::*;
(
	input wire logic clock,
	input wire logic we,
	input wire logic [5:0] wslot,
	input wire logic [8:0] wbyte,
	input wire logic [7:0] wdata,
	input wire logic [5:0] rslot,
	input wire logic [8:0] rbyte,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:LOG_SLOTS*SECTOR_BYTES-1];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[{wslot, wbyte}] <= wdata;
		end
	end

	assign rdata = mem[{rslot, rbyte}];
endmodule
`default_nettype wire

// [verilog/smls_attr_gen.sv]
/*
 * byte generator of the 512-byte attribute data structure, little endian.
 * assumes attribute entry bytes come from an outside store addressed by
 * the same byte index; the checksum byte is added by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module smls_attr_gen
	import smls_pkg::*;
(
	input wire logic [8:0] idx,
	input wire logic [7:0] entry_byte,
	input wire smls_devstat_t stat,
	output logic [7:0] byte_out
);
	always_comb begin
		byte_out = 8'h00; // reserved and vendor areas
		if (idx == 9'h000) byte_out = ATTR_REVISION[7:0];
		else if (idx == 9'h001) byte_out = ATTR_REVISION[15:8];
		else if (idx >= OFS_ENTRIES && idx < OFS_OFFL_STAT) byte_out = entry_byte;
		else if (idx == OFS_OFFL_STAT) byte_out = stat.offl_stat;
		else if (idx == OFS_ST_STAT) byte_out = stat.st_stat;
		else if (idx == OFS_OFFL_TIME) byte_out = stat.offl_time[7:0];
		else if (idx == 9'(OFS_OFFL_TIME + 9'h001)) byte_out = stat.offl_time[15:8];
		else if (idx == OFS_SEG_PTR) byte_out = stat.seg_ptr;
		else if (idx == OFS_OFFL_CAP) byte_out = VAL_OFFL_CAP;
		else if (idx == OFS_MON_CAP) byte_out = VAL_MON_CAP[7:0];
		else if (idx == 9'(OFS_MON_CAP + 9'h001)) byte_out = VAL_MON_CAP[15:8];
		else if (idx == OFS_ERRLOG_CAP) byte_out = VAL_ERRLOG_CAP;
		else if (idx == OFS_CHKPT) byte_out = stat.chkpt;
		else if (idx == OFS_SHORT_MIN) byte_out = stat.short_min;
		else if (idx == OFS_EXT_MIN) byte_out = stat.ext_min;
	end
endmodule
`default_nettype wire

// [verilog/smls_core.sv]
/*
 * health-monitoring subcommand interpreter behind a task-file style
 * register port: log read/write, monitoring enable/disable, status return,
 * automatic off-line and read-scan control, attribute structure read.
 * assumes one 100 MHz clock, synchronous active-high reset, a master that
 * issues one-cycle strobes, and outside stores for persistent state and
 * attribute entries.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - log read: count one, address, 512 bytes
// - fixed logs read-only, selective and vendor writable
// - log write: count one, 512 bytes stored
// - write to read-only log aborts
// - no monitoring before enable; re-enable harmless
// - enable state kept non-volatile
// - disable stops monitoring and autosave
// - disabled: abort all but enable
// - keep values; update on read or save
// - status: busy, save, compare thresholds
// - healthy or advisory only: 4F, C2
// - pre-failure exceeded: F4, 2C
// - count 00 disables, F8 enables auto off-line
// - count 01/F9 control read scanning
// - read scan covers whole medium
// - power and recovery saves still happen
// - other counts change nothing, may error
// - structure is 512 bytes, little endian
// - revision 0010h then thirty entries
// - status fields at 16Ah to 16Eh
// - fixed capability bytes 5B, 0003, 01
// - self-test bytes, zero reserved, checksum 1FFh
module smls_core
	import smls_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire smls_bus_t bus,
	output logic [31:0] rdata,
	input wire smls_feat_t nv_state,
	output smls_feat_t nv_data,
	output logic nv_store,
	input wire logic prefail_exceed,
	input wire logic advisory_exceed,
	input wire logic power_event,
	output logic attr_save,
	output logic monitor_active,
	output logic autosave_active,
	output logic auto_offline_en,
	output logic offline_start,
	output logic read_scan_req,
	output logic [8:0] attr_idx,
	input wire logic [7:0] attr_byte,
	input wire smls_devstat_t dev_stat,
	input wire logic fw_log_we,
	input wire logic [5:0] fw_log_slot,
	input wire logic [8:0] fw_log_byte,
	input wire logic [7:0] fw_log_data
);
	typedef struct packed {
		smls_fsm_t fsm;
		logic [8:0] cnt;
		logic [7:0] feat;
		logic [7:0] seccnt;
		logic [7:0] lba_low;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
		logic bsy;
		logic err;
		logic drq;
		logic abrt;
		logic [5:0] slot;
		logic xfer_attr;
		logic [7:0] csum;
		smls_feat_t ft;
		logic nv_loaded;
		logic [31:0] rdata;
		logic save;
		logic offl_go;
		logic nv_store;
	} smls_state_t;

	smls_state_t s_q, s_d;
	logic [7:0] log_byte;
	logic [7:0] gen_byte;
	logic [7:0] cur_byte;
	logic ram_we;
	logic [5:0] ram_wslot;
	logic [8:0] ram_wbyte;
	logic [7:0] ram_wdata;
	logic host_wr;
	smls_logmap_t lmap;

	function automatic logic [31:0] status_word(input smls_state_t st);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[STAT_BSY_BIT] = st.bsy;
		w[STAT_DRDY_BIT] = ~st.bsy;
		w[STAT_DRQ_BIT] = st.drq;
		w[STAT_ERR_BIT] = st.err;
		return w;
	endfunction

	assign lmap = smls_log_map(s_q.lba_low);
	assign attr_idx = s_q.cnt;

	smls_attr_gen u_gen (
		.idx(s_q.cnt),
		.entry_byte(attr_byte),
		.stat(dev_stat),
		.byte_out(gen_byte)
	);

	// host data wins the single write port; a firmware write in the same cycle is lost
	assign host_wr = bus.we && bus.addr == REG_DATA && s_q.fsm == SMLS_WR;
	assign ram_we = host_wr | fw_log_we;
	assign ram_wslot = host_wr ? s_q.slot : fw_log_slot;
	assign ram_wbyte = host_wr ? s_q.cnt : fw_log_byte;
	assign ram_wdata = host_wr ? bus.wdata[7:0] : fw_log_data;

	smls_log_ram u_ram (
		.clock(clock),
		.we(ram_we),
		.wslot(ram_wslot),
		.wbyte(ram_wbyte),
		.wdata(ram_wdata),
		.rslot(s_q.slot),
		.rbyte(s_q.cnt),
		.rdata(log_byte)
	);

	always_comb begin
		if (!s_q.xfer_attr) cur_byte = log_byte;
		else if (s_q.cnt == OFS_CHECKSUM) cur_byte = 8'(8'h00 - s_q.csum);
		else cur_byte = gen_byte;
	end

	always_comb begin
		s_d = s_q;
		s_d.save = 1'b0;
		s_d.offl_go = 1'b0;
		s_d.nv_store = 1'b0;
		// persistent state is taken once, a cycle after reset release
		if (!s_q.nv_loaded) begin
			s_d.ft = nv_state;
			s_d.nv_loaded = 1'b1;
		end
		// saves tied to power and recovery events ignore every feature bit
		if (power_event) s_d.save = 1'b1;
		if (bus.re) begin
			unique case (bus.addr)
				REG_FEATURE: s_d.rdata = {24'h00_0000, s_q.feat};
				REG_SECCNT: s_d.rdata = {24'h00_0000, s_q.seccnt};
				REG_LBA_LOW: s_d.rdata = {24'h00_0000, s_q.lba_low};
				REG_LBA_MID: s_d.rdata = {24'h00_0000, s_q.lba_mid};
				REG_LBA_HIGH: s_d.rdata = {24'h00_0000, s_q.lba_high};
				REG_CMD_STAT: s_d.rdata = status_word(s_q);
				REG_ERROR: s_d.rdata = {29'h0000_0000, s_q.abrt, 2'b00};
				REG_FEAT_STATE: s_d.rdata = {28'h000_0000, s_q.ft};
				REG_DATA: begin
					s_d.rdata = 32'h0000_0000;
					if (s_q.fsm == SMLS_RD) begin
						s_d.rdata = {24'h00_0000, cur_byte};
						s_d.csum = 8'(s_q.csum + cur_byte);
						s_d.cnt = 9'(s_q.cnt + 9'h001);
						if (s_q.cnt == LAST_BYTE) begin
							s_d.fsm = SMLS_IDLE;
							s_d.drq = 1'b0;
							s_d.cnt = 9'h000;
						end
					end
				end
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (bus.we) begin
			if (bus.addr == REG_DATA && s_q.fsm == SMLS_WR) begin
				s_d.cnt = 9'(s_q.cnt + 9'h001);
				if (s_q.cnt == LAST_BYTE) begin
					s_d.fsm = SMLS_IDLE;
					s_d.drq = 1'b0;
					s_d.cnt = 9'h000;
				end
			end else if (s_q.fsm == SMLS_IDLE) begin
				if (bus.addr == REG_FEATURE) s_d.feat = bus.wdata[7:0];
				if (bus.addr == REG_SECCNT) s_d.seccnt = bus.wdata[7:0];
				if (bus.addr == REG_LBA_LOW) s_d.lba_low = bus.wdata[7:0];
				if (bus.addr == REG_LBA_MID) s_d.lba_mid = bus.wdata[7:0];
				if (bus.addr == REG_LBA_HIGH) s_d.lba_high = bus.wdata[7:0];
				if (bus.addr == REG_CMD_STAT) begin
					s_d.err = 1'b0;
					s_d.abrt = 1'b0;
					s_d.cnt = 9'h000;
					s_d.csum = 8'h00;
					s_d.xfer_attr = 1'b0;
					if (bus.wdata[7:0] != CMD_HEALTH) begin
						s_d.abrt = 1'b1;
					end else if (!s_q.ft.mon_en && s_q.feat != SUB_ENABLE) begin
						s_d.abrt = 1'b1;
					end else begin
						unique case (s_q.feat)
							SUB_ENABLE: begin
								// attribute values untouched on a repeat
								s_d.ft.mon_en = 1'b1;
							end
							SUB_DISABLE: begin
								s_d.ft.mon_en = 1'b0;
								s_d.ft.autosave = 1'b0;
							end
							SUB_READ_ATTR: begin
								s_d.save = 1'b1;
								s_d.xfer_attr = 1'b1;
								s_d.fsm = SMLS_RD;
								s_d.drq = 1'b1;
							end
							SUB_SAVE_ATTR: s_d.save = 1'b1;
							SUB_STATUS: begin
								s_d.bsy = 1'b1;
								s_d.save = 1'b1;
								s_d.fsm = SMLS_BUSY;
							end
							SUB_AUTOSAVE: begin
								if (s_q.seccnt == SC_AUTOSAVE_EN) s_d.ft.autosave = 1'b1;
								else if (s_q.seccnt == 8'h00) s_d.ft.autosave = 1'b0;
								else s_d.abrt = 1'b1;
							end
							SUB_AUTO_OFF: begin
								if (s_q.seccnt == SC_AUTO_OFF_DIS) begin
									s_d.ft.auto_off = 1'b0;
								end else if (s_q.seccnt == SC_AUTO_OFF_EN) begin
									s_d.ft.auto_off = 1'b1;
								end else if (s_q.seccnt == SC_SCAN_DIS) begin
									s_d.ft.read_scan = 1'b0;
								end else if (s_q.seccnt == SC_SCAN_EN) begin
									s_d.ft.read_scan = 1'b1;
								end else begin
									s_d.abrt = 1'b1;
								end
							end
							SUB_EXEC_IMM: begin
								if (s_q.lba_low == EXEC_OFFLINE) s_d.offl_go = 1'b1;
							end
							SUB_READ_LOG: begin
								if (s_q.seccnt != SC_ONE || !lmap.valid) begin
									s_d.abrt = 1'b1;
								end else begin
									s_d.slot = lmap.slot;
									s_d.fsm = SMLS_RD;
									s_d.drq = 1'b1;
								end
							end
							SUB_WRITE_LOG: begin
								if (s_q.seccnt != SC_ONE || !lmap.valid) begin
									s_d.abrt = 1'b1;
								end else if (!lmap.writable) begin
									s_d.abrt = 1'b1;
								end else begin
									s_d.slot = lmap.slot;
									s_d.fsm = SMLS_WR;
									s_d.drq = 1'b1;
								end
							end
							default: s_d.abrt = 1'b1;
						endcase
					end
					s_d.err = s_d.abrt;
				end
			end
		end
		// one busy cycle covers the save; the compare then fills the answer
		if (s_q.fsm == SMLS_BUSY) begin
			s_d.bsy = 1'b0;
			s_d.fsm = SMLS_IDLE;
			if (prefail_exceed) begin
				s_d.lba_mid = HEALTH_BAD_MID;
				s_d.lba_high = HEALTH_BAD_HIGH;
			end else begin
				// advisory exceed alone never gives the failing answer
				s_d.lba_mid = HEALTH_OK_MID;
				s_d.lba_high = HEALTH_OK_HIGH;
			end
		end
		if (s_q.nv_loaded && s_d.ft != s_q.ft) s_d.nv_store = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.fsm <= SMLS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign nv_data = s_q.ft;
	assign nv_store = s_q.nv_store;
	// command saves only while enabled; event saves always
	assign attr_save = s_q.save;
	assign monitor_active = s_q.ft.mon_en;
	assign autosave_active = s_q.ft.mon_en & s_q.ft.autosave;
	assign auto_offline_en = s_q.ft.mon_en & s_q.ft.auto_off;
	assign offline_start = s_q.offl_go;
	// scan runs only with an off-line pass started by the host, not with automatic off-line
	assign read_scan_req = s_q.ft.read_scan & s_q.offl_go;
endmodule
`default_nettype wire

// [test/smls_core_monitor.sv]
/*
 * checker of the health subcommand core: feature levels, pulses, read data.
 * assumes a bind onto smls_core, one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module smls_core_monitor
	import smls_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire smls_bus_t bus,
	input wire logic [31:0] rdata,
	input wire smls_feat_t nv_data,
	input wire logic nv_store,
	input wire logic monitor_active,
	input wire logic autosave_active,
	input wire logic auto_offline_en,
	input wire logic offline_start,
	input wire logic read_scan_req,
	input wire logic attr_save
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_mon_level;
		monitor_active == nv_data.mon_en;
	endproperty
	a_mon_level: assert property (p_mon_level) else $error("monitor level off state");
	property p_autosave;
		autosave_active == (nv_data.mon_en && nv_data.autosave);
	endproperty
	a_autosave: assert property (p_autosave) else $error("autosave level wrong");
	property p_auto_off;
		auto_offline_en == (nv_data.mon_en && nv_data.auto_off);
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("auto off-line level wrong");
	property p_scan_pair;
		read_scan_req |-> offline_start;
	endproperty
	a_scan_pair: assert property (p_scan_pair) else $error("scan without start");
	property p_scan_state;
		offline_start |-> read_scan_req == nv_data.read_scan;
	endproperty
	a_scan_state: assert property (p_scan_state) else $error("scan request wrong");
	property p_start_enabled;
		offline_start |-> monitor_active;
	endproperty
	a_start_enabled: assert property (p_start_enabled) else $error("start while off");
	property p_rdata_hold;
		!$past(bus.re) |-> $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_store_change;
		nv_store |-> nv_data != $past(nv_data);
	endproperty
	a_store_change: assert property (p_store_change) else $error("store without change");
	property p_enable_cause;
		$rose(monitor_active) |-> $past(bus.we && bus.addr == REG_CMD_STAT) || $past(sys_rst, 2);
	endproperty
	a_enable_cause: assert property (p_enable_cause) else $error("enable without command");
	c_start: cover property (offline_start);
	c_enable: cover property ($rose(monitor_active));
	c_save: cover property (attr_save);
endmodule
bind smls_core smls_core_monitor u_monitor (.clock(clock), .sys_rst(sys_rst), .bus(bus),
	.rdata(rdata), .nv_data(nv_data), .nv_store(nv_store), .monitor_active(monitor_active),
	.autosave_active(autosave_active), .auto_offline_en(auto_offline_en),
	.offline_start(offline_start), .read_scan_req(read_scan_req), .attr_save(attr_save));
`default_nettype wire

// [test/smls_host.sv]
/*
 * host side: register master tasks, persistent feature store, entry store.
 * assumes tasks are called right after a rising edge of clock.
 */
`timescale 1ns/1ps
`default_nettype none
module smls_host
	import smls_pkg::*;
(
	input wire logic clock,
	input wire logic [31:0] rdata,
	output smls_bus_t bus,
	input wire smls_feat_t nv_data,
	input wire logic nv_store,
	output var smls_feat_t nv_state,
	input wire logic [8:0] attr_idx,
	output logic [7:0] attr_byte
);
	initial begin
		bus = '0;
		nv_state = '0;
	end
	// no reset here: must survive the core's reset
	always @(posedge clock) begin
		if (nv_store) begin
			nv_state <= nv_data;
		end
	end
	// index-dependent so a shifted byte shows
	assign attr_byte = attr_idx[7:0] ^ 8'hA5;
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		#1 bus <= '{addr: a, wdata: {24'h00_0000, d}, we: 1'b1, re: 1'b0};
		@(posedge clock);
		bus <= '0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		#1 bus <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
		@(posedge clock);
		bus <= '0;
		#1 d = rdata;
	endtask
endmodule
`default_nettype wire

// [test/smls_core_tb.sv]
/*
 * self-checking bench of the health subcommand core.
 * assumes smls_host as register master and store, checker bound by itself.
 */
`timescale 1ns/1ps
`default_nettype none
module smls_core_tb
	import smls_pkg::*;
;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic prefail_exceed = 1'b0;
	logic advisory_exceed = 1'b0;
	logic power_event = 1'b0;
	smls_bus_t bus;
	smls_feat_t nv_state, nv_data;
	logic [31:0] rdata, v;
	logic nv_store, attr_save, monitor_active, autosave_active, auto_offline_en, ok;
	logic offline_start, read_scan_req;
	logic [8:0] attr_idx;
	logic [7:0] attr_byte, e, s;
	smls_devstat_t ds = 64'h8211_2233_4455_6677;
	logic [7:0] sc_tab [5] = '{8'h00, 8'h01, 8'hF8, 8'hF9, 8'h05};
	logic [3:0] st_tab [5] = '{4'h8, 4'h8, 4'hA, 4'hB, 4'hB};
	logic [7:0] la_tab [3] = '{LOG_SELECTIVE, LOG_VENDOR_LO, LOG_VENDOR_HI};
	int mismatches = 0;
	int n_compared = 0;
	int n_start = 0;
	int n_scan = 0;
	int n_save = 0;
	always #5 clock = ~clock;
	// pulses stand one cycle only, so they are counted as they pass
	always @(posedge clock) begin
		if (offline_start) n_start++;
		if (read_scan_req) n_scan++;
		if (attr_save) n_save++;
	end
	smls_core dut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
		.nv_state(nv_state), .nv_data(nv_data), .nv_store(nv_store),
		.prefail_exceed(prefail_exceed), .advisory_exceed(advisory_exceed),
		.power_event(power_event), .attr_save(attr_save), .monitor_active(monitor_active),
		.autosave_active(autosave_active), .auto_offline_en(auto_offline_en),
		.offline_start(offline_start), .read_scan_req(read_scan_req), .attr_idx(attr_idx),
		.attr_byte(attr_byte), .dev_stat(ds), .fw_log_we(1'b0), .fw_log_slot(6'h00),
		.fw_log_byte(9'h000), .fw_log_data(8'h00));
	smls_host host (.clock(clock), .rdata(rdata), .bus(bus), .nv_data(nv_data),
		.nv_store(nv_store), .nv_state(nv_state), .attr_idx(attr_idx), .attr_byte(attr_byte));
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, exp, seen);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
		host.rd(a, v);
		chk($sformatf("register %h", a), v, exp);
	endtask
	// status is read in the cycle right after the command, while busy still shows
	task automatic cmd(input logic [7:0] sub, sc, la, input logic err);
		host.wr(REG_FEATURE, sub);
		host.wr(REG_SECCNT, sc);
		host.wr(REG_LBA_LOW, la);
		host.wr(REG_CMD_STAT, CMD_HEALTH);
		host.rd(REG_CMD_STAT, v);
		chk("error flag", 32'(v[STAT_ERR_BIT]), 32'(err));
	endtask
	task automatic rst;
		sys_rst <= 1'b1;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	function automatic logic [7:0] pat(input int i, input logic [7:0] la);
		return 8'(i) ^ 8'(i >> 7) ^ la;
	endfunction
	function automatic logic [7:0] attr_exp(input logic [8:0] i);
		if (i < OFS_ENTRIES) return i[0] ? ATTR_REVISION[15:8] : ATTR_REVISION[7:0];
		if (i < OFS_OFFL_STAT) return i[7:0] ^ 8'hA5;
		case (i)
			OFS_OFFL_STAT: return ds.offl_stat;
			OFS_ST_STAT: return ds.st_stat;
			OFS_OFFL_TIME: return ds.offl_time[7:0];
			OFS_OFFL_TIME + 9'h001: return ds.offl_time[15:8];
			OFS_SEG_PTR: return ds.seg_ptr;
			OFS_OFFL_CAP: return VAL_OFFL_CAP;
			OFS_MON_CAP: return VAL_MON_CAP[7:0];
			OFS_MON_CAP + 9'h001: return VAL_MON_CAP[15:8];
			OFS_ERRLOG_CAP: return VAL_ERRLOG_CAP;
			OFS_CHKPT: return ds.chkpt;
			OFS_SHORT_MIN: return ds.short_min;
			OFS_EXT_MIN: return ds.ext_min;
			default: return 8'h00;
		endcase
	endfunction
	initial begin
		repeat (100000) @(posedge clock);
		mismatches++;
		conclude();
	end
	initial begin
		rst();
		cmd(SUB_DISABLE, 8'h00, 8'h00, 1'b1);
		rdc(REG_ERROR, 32'h0000_0004);
		cmd(SUB_STATUS, 8'h00, 8'h00, 1'b1);
		cmd(SUB_ENABLE, 8'h00, 8'h00, 1'b0);
		cmd(SUB_ENABLE, 8'h00, 8'h00, 1'b0);
		rdc(REG_FEAT_STATE, 32'h0000_0008);
		foreach (sc_tab[i]) begin
			cmd(SUB_AUTO_OFF, sc_tab[i], 8'h00, sc_tab[i] == 8'h05);
			rdc(REG_FEAT_STATE, 32'(st_tab[i]));
			chk("auto off-line", 32'(auto_offline_en), 32'(st_tab[i][1]));
		end
		rst();
		rdc(REG_FEAT_STATE, 32'h0000_000B);
		cmd(SUB_EXEC_IMM, 8'h00, EXEC_OFFLINE, 1'b0);
		chk("off-line start", 32'(n_start), 32'h0000_0001);
		chk("read scan", 32'(n_scan), 32'h0000_0001);
		for (int k = 0; k < 4; k++) begin
			prefail_exceed <= k[1];
			advisory_exceed <= k[0];
			cmd(SUB_STATUS, 8'h00, 8'h00, 1'b0);
			chk("busy", 32'(v[STAT_BSY_BIT]), 32'h0000_0001);
			rdc(REG_LBA_MID, k[1] ? 32'h0000_00F4 : 32'h0000_004F);
			rdc(REG_LBA_HIGH, k[1] ? 32'h0000_002C : 32'h0000_00C2);
		end
		cmd(SUB_WRITE_LOG, SC_ONE, LOG_SELFTEST, 1'b1);
		rdc(REG_ERROR, 32'h0000_0004);
		cmd(SUB_READ_LOG, 8'h02, LOG_SELECTIVE, 1'b1);
		foreach (la_tab[j]) begin
			cmd(SUB_WRITE_LOG, SC_ONE, la_tab[j], 1'b0);
			for (int i = 0; i < 512; i++) host.wr(REG_DATA, pat(i, la_tab[j]));
		end
		foreach (la_tab[j]) begin
			cmd(SUB_READ_LOG, SC_ONE, la_tab[j], 1'b0);
			for (int i = 0; i < 512; i++) rdc(REG_DATA, 32'(pat(i, la_tab[j])));
			rdc(REG_CMD_STAT, 32'h0000_0040);
			rdc(REG_DATA, 32'h0000_0000);
		end
		cmd(SUB_READ_ATTR, 8'h00, 8'h00, 1'b0);
		chk("attribute saves", 32'(n_save), 32'h0000_0005);
		s = 8'h00;
		for (int i = 0; i < 512; i++) begin
			e = (i == 511) ? -s : attr_exp(9'(i));
			s += e;
			rdc(REG_DATA, 32'(e));
		end
		cmd(SUB_AUTOSAVE, SC_AUTOSAVE_EN, 8'h00, 1'b0);
		chk("autosave", 32'(autosave_active), 32'h0000_0001);
		cmd(SUB_DISABLE, 8'h00, 8'h00, 1'b0);
		chk("autosave", 32'(autosave_active), 32'h0000_0000);
		chk("monitor", 32'(monitor_active), 32'h0000_0000);
		power_event <= 1'b1;
		@(posedge clock);
		power_event <= 1'b0;
		ok = 1'b0;
		repeat (4) begin
			#1 ok |= attr_save;
			@(posedge clock);
		end
		chk("power save", 32'(ok), 32'h0000_0001);
		cmd(SUB_DISABLE, 8'h00, 8'h00, 1'b1);
		cmd(SUB_SAVE_ATTR, 8'h00, 8'h00, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
